// ---- common/servo_seq_regs.svh ----
// Register offsets, field positions, reset values and timing constants of the servo sequencer
`ifndef SERVO_SEQ_REGS_SVH
`define SERVO_SEQ_REGS_SVH

`define SEQ_REG_EXTRA 8'h00
`define SEQ_REG_OVS2 8'h04
`define SEQ_REG_LATCH 8'h08
`define SEQ_REG_OSC 8'h0c
`define SEQ_REG_MASK 8'h10
`define SEQ_REG_SEQSEL 8'h14
`define SEQ_REG_STALL 8'h18
`define SEQ_REG_RUNDLY 8'h1c
`define SEQ_REG_BRKSPD 8'h20
`define SEQ_REG_FILT 8'h24
`define SEQ_REG_STATUS 8'h28
`define SEQ_REG_WARN 8'h2c

`define SEQ_SEL_SVOFF_LSB 0
`define SEQ_SEL_MAIN_LSB 4
`define SEQ_SEL_ALARM_LSB 8
`define SEQ_SEL_CLR_BIT 12
`define SEQ_SEL_DB_BIT 0
`define SEQ_SEL_PWR_BIT 1
`define SEQ_WARN_OSC_BIT 0

`define SEQ_RST_OVS2 15'h0000
`define SEQ_RST_STALL 16'h0000
`define SEQ_RST_RUNDLY 16'h0000
`define SEQ_RST_FILT 8'h00
`define SEQ_RST_SEQSEL 13'h0000

`define SEQ_CLK_NS 8
`define SEQ_MS_NS 1000000
`define SEQ_INIT_BASE_MS 1500
`define SEQ_EXTRA_STEP_MS 100
`define SEQ_LATCH_STEP_MS 1000
`define SEQ_CLR_FIXED_MS 120
`define SEQ_STOP_RPM 30

`endif

// ---- common/servo_seq_pkg.sv ----
// Types shared by the servo sequencer
package servo_seq_pkg;
  typedef enum logic [2:0] {ST_INIT, ST_OFF, ST_ON, ST_STALL_OFF, ST_RUN_OFF, ST_ALARM} seq_state_e;
endpackage

// ---- rtl/servo_ms_timer.sv ----
// Millisecond tick counter that runs while enabled and reports reaching its limit
`timescale 1ns/1ns
`default_nettype none
module servo_ms_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
      count_q <= '0;
    else if (tick && count_q < limit)
      count_q <= count_q + 1'b1;
  end

  // Compare with >= so a limit lowered mid-run still ends the wait
  assign done = run && (count_q >= limit);
endmodule // servo_ms_timer
`default_nettype wire

// ---- rtl/servo_drive_sequence_control.sv ----
// Servo drive power-up, enable, brake, alarm and warning sequencing
`timescale 1ns/1ns
`default_nettype none
`include "servo_seq_regs.svh"
module servo_drive_sequence_control #(
  parameter int CYC_PER_MS = `SEQ_MS_NS / `SEQ_CLK_NS
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic SERVO_ENABLE_IN,
  input wire logic FAULT_CLEAR_IN,
  input wire logic MAIN_POWER_OK,
  input wire logic FAULT_DETECT,
  input wire logic [15:0] WARN_IN,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic [10:0] TORQUE_VIB,
  output logic SERVO_READY_SIGNAL,
  output logic FAULT_INDICATOR_OUT,
  output logic BRAKE_RELEASE_OUT,
  output logic DYN_BRAKE_OUT,
  output logic MOTOR_POWER_OUT,
  output logic OVERSPEED2_OUT,
  output logic PROTECT_ACTIVE,
  output logic [15:0] WARNING_OUT
);
  localparam logic [15:0] STOP_RPM = 16'(`SEQ_STOP_RPM);

  if (CYC_PER_MS < 2)
    $error("CYC_PER_MS must be at least 2");

  servo_seq_pkg::seq_state_e state_q, state_d;
  logic [6:0] extra_q;
  logic [14:0] ovs2_lvl_q, brk_spd_q;
  logic [3:0] latch_q;
  logic [9:0] osc_lvl_q;
  logic [15:0] mask_q, stall_q, rundly_q, warn_q, raw_warn;
  logic [12:0] seqsel_q;
  logic [7:0] filt_q;
  logic [31:0] pre_q;
  logic tick;
  logic init_done_q, brk_done_q, ovs2_q, stopped, ready_w;
  logic init_tmr_done, brk_tmr_done, clr_tmr_done, latch_tmr_done;
  logic [2:0] sync_q [3];
  logic [2:0] pin_q;
  logic en_pin, clr_pin, pwr_pin;
  logic [3:0] svoff_sel, main_sel, alarm_sel;
  logic db_d, pwr_d, brk_rel_d;
  logic [15:0] init_limit, clr_limit, latch_limit;
  logic warn_wr;
  logic [15:0] status_w;

  // Three-stage pin synchroniser; the value moves once the last two stages agree
  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
        sync_q[i] <= 3'h0;
      else
        sync_q[i] <= {sync_q[i][1:0], i == 0 ? SERVO_ENABLE_IN : (i == 1 ? FAULT_CLEAR_IN : MAIN_POWER_OK)};
    end
    always_ff @(posedge CLK)
    begin
      if (!RST_N)
        pin_q[i] <= 1'b0;
      else if (sync_q[i][1] == sync_q[i][2])
        pin_q[i] <= sync_q[i][2];
    end
  end
  assign en_pin = pin_q[0];
  assign clr_pin = pin_q[1];
  assign pwr_pin = pin_q[2];

  always_ff @(posedge CLK)
  begin
    if (!RST_N || pre_q == 32'(CYC_PER_MS - 1))
      pre_q <= 32'h0;
    else
      pre_q <= pre_q + 32'h1;
  end
  assign tick = (pre_q == 32'(CYC_PER_MS - 1));

  // Settings registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      extra_q <= 7'h00;
      ovs2_lvl_q <= `SEQ_RST_OVS2;
      latch_q <= 4'h0;
      osc_lvl_q <= 10'h000;
      mask_q <= 16'h0000;
      seqsel_q <= `SEQ_RST_SEQSEL;
      stall_q <= `SEQ_RST_STALL;
      rundly_q <= `SEQ_RST_RUNDLY;
      brk_spd_q <= 15'h0000;
      filt_q <= `SEQ_RST_FILT;
    end
    else if (WR)
    begin
      unique case (ADDR)
        `SEQ_REG_EXTRA: extra_q <= WDATA[6:0];
        `SEQ_REG_OVS2: ovs2_lvl_q <= WDATA[14:0];
        `SEQ_REG_LATCH: latch_q <= WDATA[3:0];
        `SEQ_REG_OSC: osc_lvl_q <= WDATA[9:0];
        `SEQ_REG_MASK: mask_q <= WDATA;
        `SEQ_REG_SEQSEL: seqsel_q <= WDATA[12:0];
        `SEQ_REG_STALL: stall_q <= WDATA;
        `SEQ_REG_RUNDLY: rundly_q <= WDATA;
        `SEQ_REG_BRKSPD: brk_spd_q <= WDATA[14:0];
        `SEQ_REG_FILT: filt_q <= WDATA[7:0];
        default: ;
      endcase
    end
  end
  assign warn_wr = WR && ADDR == `SEQ_REG_WARN;

  assign status_w = {4'h0, en_pin, pwr_pin, ovs2_q, MOTOR_POWER_OUT, DYN_BRAKE_OUT, BRAKE_RELEASE_OUT,
                     FAULT_INDICATOR_OUT, SERVO_READY_SIGNAL, init_done_q, state_q};

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !RD)
      RDATA <= 16'h0000;
    else
    begin
      unique case (ADDR)
        `SEQ_REG_EXTRA: RDATA <= {9'h000, extra_q};
        `SEQ_REG_OVS2: RDATA <= {1'b0, ovs2_lvl_q};
        `SEQ_REG_LATCH: RDATA <= {12'h000, latch_q};
        `SEQ_REG_OSC: RDATA <= {6'h00, osc_lvl_q};
        `SEQ_REG_MASK: RDATA <= mask_q;
        `SEQ_REG_SEQSEL: RDATA <= {3'h0, seqsel_q};
        `SEQ_REG_STALL: RDATA <= stall_q;
        `SEQ_REG_RUNDLY: RDATA <= rundly_q;
        `SEQ_REG_BRKSPD: RDATA <= {1'b0, brk_spd_q};
        `SEQ_REG_FILT: RDATA <= {8'h00, filt_q};
        `SEQ_REG_STATUS: RDATA <= status_w;
        `SEQ_REG_WARN: RDATA <= warn_q;
        default: RDATA <= 16'h0000;
      endcase
    end
  end

  assign svoff_sel = seqsel_q[`SEQ_SEL_SVOFF_LSB +: 4];
  assign main_sel = seqsel_q[`SEQ_SEL_MAIN_LSB +: 4];
  assign alarm_sel = seqsel_q[`SEQ_SEL_ALARM_LSB +: 4];
  assign stopped = MOTOR_SPEED <= STOP_RPM;
  assign ready_w = init_done_q && pwr_pin && state_q != servo_seq_pkg::ST_ALARM;

  assign init_limit = 16'(`SEQ_INIT_BASE_MS) + 16'(extra_q) * 16'(`SEQ_EXTRA_STEP_MS);
  assign clr_limit = seqsel_q[`SEQ_SEL_CLR_BIT] ? {8'h00, filt_q} : 16'(`SEQ_CLR_FIXED_MS);
  assign latch_limit = 16'(latch_q) * 16'(`SEQ_LATCH_STEP_MS);

  servo_ms_timer #(.W(16)) u_init_tmr (
    .clk(CLK), .rst_n(RST_N), .tick(tick), .run(!init_done_q), .limit(init_limit), .done(init_tmr_done)
  );
  servo_ms_timer #(.W(16)) u_brk_tmr (
    .clk(CLK), .rst_n(RST_N), .tick(tick),
    .run(!brk_done_q && (state_q == servo_seq_pkg::ST_STALL_OFF || state_q == servo_seq_pkg::ST_RUN_OFF ||
         state_q == servo_seq_pkg::ST_ALARM)),
    .limit(state_q == servo_seq_pkg::ST_STALL_OFF ? stall_q : rundly_q), .done(brk_tmr_done)
  );
  servo_ms_timer #(.W(16)) u_clr_tmr (
    .clk(CLK), .rst_n(RST_N), .tick(tick), .run(state_q == servo_seq_pkg::ST_ALARM && clr_pin),
    .limit(clr_limit), .done(clr_tmr_done)
  );
  servo_ms_timer #(.W(16)) u_latch_tmr (
    .clk(CLK), .rst_n(RST_N), .tick(tick), .run(latch_q != 4'h0 && warn_q != 16'h0000 && raw_warn == 16'h0000),
    .limit(latch_limit), .done(latch_tmr_done)
  );

  // Protection ignores fault and warning inputs until the power-up wait ends
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      init_done_q <= 1'b0;
    else if (init_tmr_done)
      init_done_q <= 1'b1;
  end
  assign PROTECT_ACTIVE = init_done_q;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      servo_seq_pkg::ST_INIT:
        if (init_tmr_done)
          state_d = FAULT_DETECT ? servo_seq_pkg::ST_ALARM : servo_seq_pkg::ST_OFF;
      servo_seq_pkg::ST_OFF:
        if (FAULT_DETECT)
          state_d = servo_seq_pkg::ST_ALARM;
        else if (en_pin && ready_w && stopped)
          state_d = servo_seq_pkg::ST_ON;
      servo_seq_pkg::ST_ON:
        if (FAULT_DETECT)
          state_d = servo_seq_pkg::ST_ALARM;
        else if (!en_pin || !pwr_pin)
          state_d = stopped ? servo_seq_pkg::ST_STALL_OFF : servo_seq_pkg::ST_RUN_OFF;
      servo_seq_pkg::ST_STALL_OFF:
        if (FAULT_DETECT)
          state_d = servo_seq_pkg::ST_ALARM;
        else if (brk_done_q)
          state_d = servo_seq_pkg::ST_OFF;
      servo_seq_pkg::ST_RUN_OFF:
        if (FAULT_DETECT)
          state_d = servo_seq_pkg::ST_ALARM;
        else if (brk_done_q && stopped)
          state_d = servo_seq_pkg::ST_OFF;
      servo_seq_pkg::ST_ALARM:
        if (clr_tmr_done && !FAULT_DETECT)
          state_d = servo_seq_pkg::ST_OFF;
      default: state_d = servo_seq_pkg::ST_ALARM;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      state_q <= servo_seq_pkg::ST_INIT;
    else
      state_q <= state_d;
  end

  // Brake applied flag: delay expiry at standstill; first of delay expiry or slow speed when running or in alarm
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      brk_done_q <= 1'b1;
    else if (state_q == servo_seq_pkg::ST_ON)
      brk_done_q <= 1'b0;
    else if (state_q == servo_seq_pkg::ST_STALL_OFF)
      brk_done_q <= brk_done_q || brk_tmr_done;
    else if (state_q == servo_seq_pkg::ST_RUN_OFF || state_q == servo_seq_pkg::ST_ALARM)
      brk_done_q <= brk_done_q || brk_tmr_done || MOTOR_SPEED <= {1'b0, brk_spd_q};
    else
      brk_done_q <= 1'b1;
  end

  // Second over-speed stays until the alarm is cleared
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ovs2_q <= 1'b0;
    else if (state_q == servo_seq_pkg::ST_ALARM && !stopped && MOTOR_SPEED > {1'b0, ovs2_lvl_q})
      ovs2_q <= 1'b1;
    else if (state_q != servo_seq_pkg::ST_ALARM)
      ovs2_q <= 1'b0;
  end

  always_comb
  begin
    db_d = 1'b0;
    pwr_d = 1'b0;
    brk_rel_d = !brk_done_q;
    unique case (state_q)
      servo_seq_pkg::ST_INIT: db_d = main_sel[`SEQ_SEL_DB_BIT];
      servo_seq_pkg::ST_OFF:
        db_d = (init_done_q && pwr_pin) ? svoff_sel[`SEQ_SEL_DB_BIT] : main_sel[`SEQ_SEL_DB_BIT];
      servo_seq_pkg::ST_ON:
      begin
        pwr_d = 1'b1;
        brk_rel_d = 1'b1;
      end
      servo_seq_pkg::ST_STALL_OFF:
      begin
        // Torque holds the load until the brake has engaged
        pwr_d = !brk_done_q;
        db_d = brk_done_q && svoff_sel[`SEQ_SEL_DB_BIT];
      end
      servo_seq_pkg::ST_RUN_OFF:
      begin
        pwr_d = svoff_sel[`SEQ_SEL_PWR_BIT];
        db_d = svoff_sel[`SEQ_SEL_DB_BIT];
      end
      servo_seq_pkg::ST_ALARM: db_d = alarm_sel[`SEQ_SEL_DB_BIT];
      default: ;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      DYN_BRAKE_OUT <= 1'b0;
      MOTOR_POWER_OUT <= 1'b0;
      BRAKE_RELEASE_OUT <= 1'b0;
      SERVO_READY_SIGNAL <= 1'b0;
      FAULT_INDICATOR_OUT <= 1'b0;
      OVERSPEED2_OUT <= 1'b0;
    end
    else
    begin
      DYN_BRAKE_OUT <= db_d;
      MOTOR_POWER_OUT <= pwr_d;
      BRAKE_RELEASE_OUT <= brk_rel_d;
      SERVO_READY_SIGNAL <= ready_w;
      FAULT_INDICATOR_OUT <= init_done_q && state_q != servo_seq_pkg::ST_ALARM;
      OVERSPEED2_OUT <= ovs2_q;
    end
  end

  // Masked warnings never latch; new events beat a clear in the same cycle
  always_comb
  begin
    raw_warn = WARN_IN;
    raw_warn[`SEQ_WARN_OSC_BIT] = WARN_IN[`SEQ_WARN_OSC_BIT] || TORQUE_VIB > {1'b0, osc_lvl_q};
    raw_warn = init_done_q ? (raw_warn & ~mask_q) : 16'h0000;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      warn_q <= 16'h0000;
    else if (latch_tmr_done)
      warn_q <= raw_warn;
    else
      warn_q <= (warn_q & ~(warn_wr ? WDATA : 16'h0000)) | raw_warn;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      WARNING_OUT <= 16'h0000;
    else
      WARNING_OUT <= warn_q;
  end

  // Checks
  logic [15:0] ms_seen_q;
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ms_seen_q <= 16'h0000;
    else if (tick && !init_done_q)
      ms_seen_q <= ms_seen_q + 16'h1;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_run_slow;
    state_q == servo_seq_pkg::ST_RUN_OFF && !FAULT_DETECT && MOTOR_SPEED <= {1'b0, brk_spd_q};
  endsequence
  sequence s_brake_on;
    ##2 !BRAKE_RELEASE_OUT;
  endsequence

  chk_ovs2_set: assert property ((state_q == servo_seq_pkg::ST_ALARM && !stopped &&
    MOTOR_SPEED > {1'b0, ovs2_lvl_q}) |=> ##1 OVERSPEED2_OUT) else $error("second over-speed missed");
  chk_init_wait: assert property ($rose(init_done_q) |-> ms_seen_q == $past(init_limit))
    else $error("power-up wait wrong");
  chk_init_protect: assert property (!init_done_q |-> WARNING_OUT == 16'h0000 && !FAULT_INDICATOR_OUT)
    else $error("protection active before wait");
  chk_latch_forever: assert property ((latch_q == 4'h0 && warn_q[3] && !warn_wr) |=> warn_q[3])
    else $error("infinite latch lost");
  chk_osc_warn: assert property ((init_done_q && TORQUE_VIB > {1'b0, osc_lvl_q} && !mask_q[`SEQ_WARN_OSC_BIT])
    |=> warn_q[`SEQ_WARN_OSC_BIT]) else $error("oscillation warning missed");
  chk_mask_block: assert property ((mask_q[5] && !warn_q[5]) |=> !warn_q[5])
    else $error("masked warning latched");
  chk_fault_ind: assert property (($rose(init_done_q) && state_q != servo_seq_pkg::ST_ALARM) |=>
    FAULT_INDICATOR_OUT) else $error("fault indicator not on");
  chk_ready_cond: assert property (SERVO_READY_SIGNAL |-> $past(init_done_q && pwr_pin))
    else $error("ready without init and power");
  chk_off_db: assert property ((state_q == servo_seq_pkg::ST_OFF && init_done_q && pwr_pin) |=>
    DYN_BRAKE_OUT == $past(svoff_sel[`SEQ_SEL_DB_BIT])) else $error("off brake choice wrong");
  chk_stall_hold: assert property ((state_q == servo_seq_pkg::ST_STALL_OFF && !brk_done_q) |=>
    BRAKE_RELEASE_OUT && MOTOR_POWER_OUT) else $error("stall brake too early");
  chk_on_slow: assert property ((state_q == servo_seq_pkg::ST_ON && $past(state_q) != servo_seq_pkg::ST_ON)
    |-> $past(MOTOR_SPEED) <= STOP_RPM) else $error("servo-on while turning");
  chk_run_brake: assert property (s_run_slow |-> s_brake_on)
    else $error("running brake late");
  chk_run_power: assert property ((state_q == servo_seq_pkg::ST_RUN_OFF) |=>
    MOTOR_POWER_OUT == $past(svoff_sel[`SEQ_SEL_PWR_BIT])) else $error("decel power choice wrong");
  chk_alarm_db: assert property ((state_q == servo_seq_pkg::ST_ALARM) |=>
    DYN_BRAKE_OUT == $past(alarm_sel[`SEQ_SEL_DB_BIT])) else $error("alarm brake choice wrong");
  chk_clear_hold: assert property ((state_q == servo_seq_pkg::ST_ALARM && state_d == servo_seq_pkg::ST_OFF)
    |-> clr_tmr_done && clr_pin) else $error("clear without recognition");
  chk_fault_out: assert property ((state_q == servo_seq_pkg::ST_ALARM) |=>
    !SERVO_READY_SIGNAL && !FAULT_INDICATOR_OUT && !MOTOR_POWER_OUT) else $error("fault outputs wrong");
endmodule // servo_drive_sequence_control
`default_nettype wire

// ---- verification/servo_host_model.sv ----
// Host motion controller model driving servo enable and fault clear
`timescale 1ns/1ns
`default_nettype none
module servo_host_model #(
  parameter int CYC_PER_MS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic want_on,
  input wire logic clear_go,
  input wire logic [15:0] clear_cycles,
  output logic enable,
  output logic fault_clear,
  output logic cmd_ok
);
  logic [15:0] clr_q;
  logic [31:0] wait_q;
  // Enable rises only once ready is seen; a dropped request drops it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enable <= 1'b0;
    else
      enable <= want_on && (ready || enable);
  end
  // Position commands held back while motor power comes up
  always_ff @(posedge clk)
  begin
    if (!rst_n || !enable)
      wait_q <= 32'h00000000;
    else if (!cmd_ok)
      wait_q <= wait_q + 32'h00000001;
  end
  assign cmd_ok = wait_q >= 32'(100 * CYC_PER_MS);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clr_q <= 16'h0000;
    else if (clear_go)
      clr_q <= clear_cycles;
    else if (clr_q != 16'h0000)
      clr_q <= clr_q - 16'h0001;
  end
  assign fault_clear = clr_q != 16'h0000;
endmodule // servo_host_model
`default_nettype wire

// ---- verification/test_servo_drive_sequence_control.sv ----
// Self-checking bench for the servo drive sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_servo_drive_sequence_control;
  localparam int CYC = 4;
  logic clk, rst_n, wr, rd, want_on, clear_go, main_pwr, fault, enable, fclr;
  logic ready, fault_ind, brake_rel, dyn_brk, mot_pwr, ovs2, protect;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, clear_cycles, warn, speed, warn_out, rv, v, m;
  logic [10:0] vib;
  logic [31:0] seed;
  int failures = 0;
  int checks_done = 0;
  int since = 0;
  int i, k;
  logic [7:0] ra [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24};
  logic [15:0] rm [8] = '{16'h7fff, 16'h000f, 16'h03ff, 16'hffff, 16'hffff, 16'hffff, 16'h7fff, 16'h00ff};

  servo_drive_sequence_control #(.CYC_PER_MS(CYC)) uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SERVO_ENABLE_IN(enable), .FAULT_CLEAR_IN(fclr), .MAIN_POWER_OK(main_pwr),
    .FAULT_DETECT(fault), .WARN_IN(warn), .MOTOR_SPEED(speed), .TORQUE_VIB(vib), .SERVO_READY_SIGNAL(ready),
    .FAULT_INDICATOR_OUT(fault_ind), .BRAKE_RELEASE_OUT(brake_rel), .DYN_BRAKE_OUT(dyn_brk),
    .MOTOR_POWER_OUT(mot_pwr), .OVERSPEED2_OUT(ovs2), .PROTECT_ACTIVE(protect), .WARNING_OUT(warn_out));
  servo_host_model #(.CYC_PER_MS(CYC)) host (.clk(clk), .rst_n(rst_n), .ready(ready), .want_on(want_on),
    .clear_go(clear_go), .clear_cycles(clear_cycles), .enable(enable), .fault_clear(fclr), .cmd_ok());

  always #4 clk = ~clk;
  always @(posedge clk) since <= rst_n ? since + 1 : 0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int init_cyc(input int extra);
    return (1500 + 100 * extra) * CYC;
  endfunction
  function automatic logic [15:0] exp_warn(input logic [15:0] ev, input logic [15:0] mask);
    return ev & ~mask;
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Ends on a falling edge so outputs are settled when compared
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic clr(input int ms);
    wt(1);
    clear_cycles <= 16'(ms * CYC);
    clear_go <= 1'b1;
    wt(1);
    clear_go <= 1'b0;
    wt(ms * CYC + 24);
  endtask
  // Short hold must leave the alarm standing, long hold must clear it
  task automatic clr_check(input int short_ms, input int long_ms);
    clr(short_ms);
    rdd(8'h28, rv);
    `CHK(rv[2:0], 3'd5);
    clr(long_ms);
    rdd(8'h28, rv);
    `CHK(rv[2:0], 3'd1);
  endtask
  task automatic results;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    results;
  end

  initial
  begin
    clk = 0; rst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0; want_on = 0; clear_go = 0; clear_cycles = 0;
    main_pwr = 0; fault = 0; warn = 0; speed = 0; vib = 0;
    seed = 32'h0ee344dc;
    look(8);
    `CHK({ready, fault_ind, brake_rel, dyn_brk, mot_pwr, ovs2, protect, warn_out}, 23'h000000);
    // Reset leaves on a rising edge like every other stimulus
    @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 13; i++)
    begin
      rdd(8'(i * 4), rv);
      `CHK(rv, 16'h0000);
    end
    wrr(8'h00, 16'h0002);
    wrr(8'h14, 16'h0010);
    for (i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      v = seed[15:0] & rm[i % 8];
      wrr(ra[i % 8], v);
      rdd(ra[i % 8], rv);
      `CHK(rv, v);
    end
    wrr(8'h28, 16'hffff);
    rdd(8'h28, rv);
    // Status is read-only; main-off choice already shows the dynamic brake during init
    `CHK(rv, 16'h0080);
    `CHK(dyn_brk, 1'b1);
    while (since < init_cyc(2) - 16) @(posedge clk);
    look(0);
    `CHK(protect, 1'b0);
    while (since < init_cyc(2) + 16) @(posedge clk);
    look(0);
    `CHK(protect, 1'b1);
    `CHK(fault_ind, 1'b1);
    `CHK(ready, 1'b0);
    wt(1);
    main_pwr <= 1'b1;
    look(10);
    `CHK(ready, 1'b1);
    `CHK(dyn_brk, 1'b0);
    wrr(8'h18, 16'd10); wrr(8'h1c, 16'd50); wrr(8'h20, 16'd100); wrr(8'h04, 16'd500); wrr(8'h0c, 16'd100);
    wrr(8'h10, 16'h0000); wrr(8'h08, 16'h0000); wrr(8'h24, 16'd10); wrr(8'h14, 16'h0113);
    speed <= 16'd31;
    want_on <= 1'b1;
    look(20);
    `CHK(mot_pwr, 1'b0);
    wt(1);
    speed <= 16'd30;
    look(20);
    `CHK(mot_pwr, 1'b1);
    `CHK(brake_rel, 1'b1);
    wt(1);
    speed <= 16'd0;
    want_on <= 1'b0;
    look(24);
    `CHK(brake_rel, 1'b1);
    look(40);
    `CHK(brake_rel, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      wt(1);
      want_on <= 1'b1;
      wt(20);
      speed <= 16'd1000;
      wt(5);
      want_on <= 1'b0;
      look(20);
      `CHK(dyn_brk, 1'b1);
      `CHK(mot_pwr, 1'b1);
      `CHK(brake_rel, 1'b1);
      if (k == 0)
      begin
        wt(1);
        speed <= 16'd50;
        look(12);
        `CHK(brake_rel, 1'b0);
        wt(1);
        want_on <= 1'b1;
        wt(20);
        rdd(8'h28, rv);
        `CHK(rv[2:0], 3'd4);
        wt(1);
        speed <= 16'd0;
        wt(20);
        rdd(8'h28, rv);
        `CHK(rv[2:0], 3'd2);
        wt(1);
        want_on <= 1'b0;
        wt(80);
      end
      else
      begin
        look(110);
        `CHK(brake_rel, 1'b1);
        look(100);
        `CHK(brake_rel, 1'b0);
        wt(1);
        speed <= 16'd0;
        wt(20);
        rdd(8'h28, rv);
        `CHK(rv[2:0], 3'd1);
      end
    end
    wt(1);
    want_on <= 1'b1;
    wt(20);
    speed <= 16'd500;
    fault <= 1'b1;
    look(10);
    `CHK({ready, fault_ind, mot_pwr}, 3'b000);
    `CHK(dyn_brk, 1'b1);
    `CHK(ovs2, 1'b0);
    wt(1);
    speed <= 16'd501;
    look(6);
    `CHK(ovs2, 1'b1);
    wt(1);
    want_on <= 1'b0;
    fault <= 1'b0;
    speed <= 16'd0;
    clr_check(100, 130);
    `CHK({ovs2, fault_ind, ready}, 3'b011);
    wrr(8'h14, 16'h1113);
    fault <= 1'b1;
    wt(10);
    fault <= 1'b0;
    clr_check(5, 15);
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      m = seed[15:0];
      seed = lfsr(seed);
      v = seed[15:0];
      wrr(8'h10, m);
      warn <= v;
      wt(1);
      warn <= 16'h0000;
      look(40);
      `CHK(warn_out, exp_warn(v, m));
      wrr(8'h2c, 16'hffff);
    end
    wrr(8'h10, 16'h0000);
    vib <= 11'd100;
    look(6);
    `CHK(warn_out, 16'h0000);
    wt(1);
    vib <= 11'd101;
    look(6);
    `CHK(warn_out[0], 1'b1);
    wt(1);
    vib <= 11'd0;
    wrr(8'h2c, 16'hffff);
    wrr(8'h08, 16'h0001);
    warn <= 16'h0020;
    wt(1);
    warn <= 16'h0000;
    look(3900);
    `CHK(warn_out, 16'h0020);
    look(300);
    `CHK(warn_out, 16'h0000);
    results;
  end
endmodule // test_servo_drive_sequence_control
`default_nettype wire
